/* shared/sacr_cfg.svh */
// Timing constants and field layout for the conversion read control
`ifndef SACR_CFG_SVH
`define SACR_CFG_SVH
`define SACR_CLK_MHZ        20
`define SACR_START_LOW_NS   50
`define SACR_BUSY_DLY_NS    83
`define SACR_CONV_NS        4000
`define SACR_NEW_VALID_NS   50
`define SACR_OLD_VALID_NS   3700
// Least time rounds up, longest time rounds down, never below one cycle
`define SACR_CYC_UP(ns)  (((ns) * `SACR_CLK_MHZ + 999) / 1000)
`define SACR_CYC_DN(ns)  ((((ns) * `SACR_CLK_MHZ) / 1000) < 1 ? 1 : \
                          (((ns) * `SACR_CLK_MHZ) / 1000))
`define SACR_CNT_W          8
`define SACR_DATA_W         16
`define SACR_BYTE_W         8
`define SACR_SYNC_W         3
`endif

/* shared/sacr_pkg.sv */
// Types for the conversion read control
`include "sacr_cfg.svh"
package sacr_pkg;
   typedef enum logic [1:0] {
      sacr_idle,
      sacr_armed,
      sacr_convert
   } sacr_state_t;

   typedef struct packed {
      logic [`SACR_SYNC_W-1:0] rc_sync;
      logic [`SACR_SYNC_W-1:0] cs_sync;
      sacr_state_t             state;
      logic [`SACR_CNT_W-1:0]  low_cnt;
      logic [`SACR_CNT_W-1:0]  conv_cnt;
      logic [`SACR_DATA_W-1:0] out_word;
      logic                    first_done;
      logic                    busy_n;
      logic                    sample_hold;
      logic                    first_result;
      logic [`SACR_DATA_W-1:0] bits_out;
      logic [`SACR_DATA_W-1:0] bits_oe;
   } sacr_state_reg_t;
endpackage : sacr_pkg

/* logic/sacr_ctrl.sv */
// Conversion start, busy and parallel result read control
//
// Summary of operation
// - Both control lines low for 50 ns holds the sample and starts conversion; here they must stay low about three clocks.
// - Busy low for whole conversion, high again with valid result.
// - First result after power-up is undefined; flagged for host to discard.
// - Busy falls under 83 ns after a conversion is initiated; here it falls about four clocks after both lines go low.
// - Busy stays low until output register holds new two's-complement result.
// - Busy returns high, data valid, within 4 us of start.
// - Commands ignored during conversion; reads still honoured.
// - Previous result stays valid about 3.7 us into busy low.
// - New result valid on outputs 50 ns before busy rises.
// - Result driven only while read_convert high and chip select low.
// - Byte swap selects word or two byte groups on the pins.
// - Swap high exchanges upper and lower bytes; low is normal order.
// - Result bits high impedance when chip select high or read_convert low.
// - Chip select falling with read_convert high enables outputs only.
`timescale 1ns/1ps
`default_nettype none
`include "sacr_cfg.svh"

module sacr_ctrl (
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   input  wire logic                    read_convert_n,
   input  wire logic                    chip_select_n,
   input  wire logic                    byte_lane_swap,
   input  wire logic [`SACR_DATA_W-1:0] conv_result,
   output logic                         busy_n,
   output logic                         sample_hold,
   output logic                         first_result,
   output logic      [`SACR_DATA_W-1:0] result_bits_out,
   output logic      [`SACR_DATA_W-1:0] result_bits_oe
);
   import sacr_pkg::*;

   localparam int START_CYC = `SACR_CYC_UP(`SACR_START_LOW_NS);
   localparam int BUSY_CYC  = `SACR_CYC_DN(`SACR_BUSY_DLY_NS);
   localparam int CONV_CYC  = `SACR_CYC_DN(`SACR_CONV_NS);
   localparam int NEW_CYC   = `SACR_CYC_DN(`SACR_NEW_VALID_NS);
   localparam int OLD_CYC   = `SACR_CYC_DN(`SACR_OLD_VALID_NS);
   // Pins lag the word by one register, so the load comes a cycle earlier
   localparam int LOAD_CYC  = CONV_CYC - NEW_CYC - 1;
   // Agreeing synchroniser stages, second and third
   localparam int S_HI      = `SACR_SYNC_W - 1;
   localparam int S_LO      = `SACR_SYNC_W - 2;

   sacr_state_reg_t cur;
   sacr_state_reg_t next_cur;

   logic                    rc_low;
   logic                    cs_low;
   logic                    start_low;
   logic                    read_en;
   logic [`SACR_DATA_W-1:0] lane_word;

   always_comb begin
      next_cur = cur;
      // First stage only shifts; decisions use agreeing stages two and three
      next_cur.rc_sync = {cur.rc_sync[`SACR_SYNC_W-2:0], read_convert_n};
      next_cur.cs_sync = {cur.cs_sync[`SACR_SYNC_W-2:0], chip_select_n};
      rc_low = (cur.rc_sync[S_HI:S_LO] == 2'h0);
      cs_low = (cur.cs_sync[S_HI:S_LO] == 2'h0);
      // Limitation: a start pulse must span about three clocks
      start_low = rc_low && cs_low;
      read_en = (cur.rc_sync[S_HI:S_LO] == 2'h3) && cs_low;
      case (cur.state)
         sacr_idle: begin
            next_cur.low_cnt = '0;
            if (start_low) begin
               next_cur.state   = sacr_armed;
               next_cur.low_cnt = `SACR_CNT_W'(1);
            end
         end
         sacr_armed: begin
            // Glitches shorter than the least low time start nothing
            if (!start_low) begin
               next_cur.state = sacr_idle;
            end else if (int'(cur.low_cnt) + 1 >= START_CYC) begin
               next_cur.state       = sacr_convert;
               next_cur.sample_hold = 1'b1;
               next_cur.busy_n      = 1'b0;
               next_cur.conv_cnt    = '0;
            end else begin
               next_cur.low_cnt = cur.low_cnt + `SACR_CNT_W'(1);
            end
         end
         sacr_convert: begin
            // Control lines are not looked at here, so commands are lost
            next_cur.conv_cnt = cur.conv_cnt + `SACR_CNT_W'(1);
            if (int'(cur.conv_cnt) + 1 == LOAD_CYC) begin
               next_cur.out_word     = conv_result;
               next_cur.first_result = !cur.first_done;
               next_cur.first_done   = 1'b1;
            end
            if (int'(cur.conv_cnt) + 1 >= CONV_CYC) begin
               next_cur.busy_n      = 1'b1;
               next_cur.sample_hold = 1'b0;
               next_cur.state       = sacr_idle;
            end
         end
         default: begin
            next_cur.state = sacr_idle;
         end
      endcase
      lane_word = byte_lane_swap ?
         {cur.out_word[`SACR_BYTE_W-1:0],
          cur.out_word[`SACR_DATA_W-1:`SACR_BYTE_W]} : cur.out_word;
      next_cur.bits_out = lane_word;
      // Reads stay open during conversion, old word until the load
      next_cur.bits_oe = read_en ? '1 : '0;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cur              <= '0;
         cur.rc_sync      <= '1;
         cur.cs_sync      <= '1;
         cur.state        <= sacr_idle;
         cur.busy_n       <= 1'b1;
      end else begin
         cur <= next_cur;
      end
   end

   assign busy_n          = cur.busy_n;
   assign sample_hold     = cur.sample_hold;
   assign first_result    = cur.first_result;
   assign result_bits_out = cur.bits_out;
   assign result_bits_oe  = cur.bits_oe;

   // Helper: cycles since busy fell
   logic [`SACR_CNT_W-1:0] busy_age;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_age <= '0;
      end else if (busy_n) begin
         busy_age <= '0;
      end else begin
         busy_age <= busy_age + `SACR_CNT_W'(1);
      end
   end

   // Busy and conversion timing
   a_start_busy_fall: assert property (
      @(posedge clk) disable iff (!rst_n)
      (cur.state == sacr_armed && start_low
       && int'(cur.low_cnt) + 1 >= START_CYC) |=> !busy_n)
      else $error("busy did not fall on start");
   a_start_cause: assert property (
      @(posedge clk) disable iff (!rst_n)
      $fell(busy_n) |-> ($past(cur.state) == sacr_armed && $past(start_low)))
      else $error("busy fell without a command");
   a_busy_len_max: assert property (
      @(posedge clk) disable iff (!rst_n)
      !busy_n |-> int'(busy_age) < CONV_CYC)
      else $error("busy low too long");
   a_busy_rise_done: assert property (
      @(posedge clk) disable iff (!rst_n)
      $rose(busy_n) |-> $past(busy_age) == `SACR_CNT_W'(CONV_CYC - 1))
      else $error("busy rose at wrong time");
   a_rise_idle: assert property (
      @(posedge clk) disable iff (!rst_n)
      $rose(busy_n) |-> (cur.state == sacr_idle && !sample_hold))
      else $error("conversion still running at busy rise");
   a_hold_busy: assert property (
      @(posedge clk) disable iff (!rst_n)
      sample_hold == !busy_n)
      else $error("sample hold out of step with busy");
   a_ignore_cmds: assert property (
      @(posedge clk) disable iff (!rst_n)
      (cur.state == sacr_convert && start_low
       && int'(cur.conv_cnt) + 1 < CONV_CYC)
      |=> (cur.state == sacr_convert
           && cur.conv_cnt == $past(cur.conv_cnt) + `SACR_CNT_W'(1)))
      else $error("conversion restarted by a command");

   // Result word and output lanes
   a_new_word_lead: assert property (
      @(posedge clk) disable iff (!rst_n)
      $rose(busy_n) |-> $past(cur.out_word, 2) == cur.out_word)
      else $error("word not loaded a cycle before busy rise");
   a_old_word_hold: assert property (
      @(posedge clk) disable iff (!rst_n)
      (!busy_n && int'(busy_age) < OLD_CYC) |-> $stable(cur.out_word))
      else $error("previous word lost too early");
   a_swap_lanes: assert property (
      @(posedge clk) disable iff (!rst_n)
      result_bits_out == ($past(byte_lane_swap)
         ? {$past(cur.out_word[`SACR_BYTE_W-1:0]),
            $past(cur.out_word[`SACR_DATA_W-1:`SACR_BYTE_W])}
         : $past(cur.out_word)))
      else $error("byte lanes in wrong order");
   a_hiz_rule: assert property (
      @(posedge clk) disable iff (!rst_n)
      !$past(read_en) |-> result_bits_oe == '0)
      else $error("bus driven while disabled");
   a_read_drive: assert property (
      @(posedge clk) disable iff (!rst_n)
      $past(read_en) |-> result_bits_oe == '1)
      else $error("bus not driven on read");
   a_first_flag: assert property (
      @(posedge clk) disable iff (!rst_n)
      $rose(cur.first_done) |-> first_result)
      else $error("first result not flagged");
   a_first_clear: assert property (
      @(posedge clk) disable iff (!rst_n)
      ($past(cur.first_done) && $changed(cur.out_word)) |-> !first_result)
      else $error("later result flagged as first");

   c_conv: cover property (@(posedge clk) disable iff (!rst_n) $rose(busy_n));
   c_read_busy: cover property (@(posedge clk) disable iff (!rst_n)
      !busy_n && result_bits_oe == '1);
   c_swap: cover property (@(posedge clk) disable iff (!rst_n)
      byte_lane_swap && result_bits_oe == '1);
   c_cmd_ignored: cover property (@(posedge clk) disable iff (!rst_n)
      cur.state == sacr_convert && start_low);
   c_first_read: cover property (@(posedge clk) disable iff (!rst_n)
      first_result && result_bits_oe == '1);
endmodule : sacr_ctrl
`default_nettype wire

/* sim/sacr_host.sv */
// Host model driving the convert and chip select lines
`timescale 1ns/1ps
`default_nettype none
module sacr_host (
   input  wire logic clk,
   output var  logic read_convert_n,
   output var  logic chip_select_n
);
   initial begin
      read_convert_n = 1'b1;
      chip_select_n  = 1'b1;
   end
   // Lines held three cycles, well past 50 ns and just enough for the sync filter
   task automatic convert(input logic cs_mode);
      if (cs_mode) begin
         read_convert_n = 1'b0;
         @(negedge clk);
      end
      chip_select_n  = 1'b0;
      read_convert_n = 1'b0;
      repeat (3) @(negedge clk);
      read_convert_n = 1'b1;
      chip_select_n  = cs_mode;
   endtask : convert
   task automatic read(input logic on);
      read_convert_n = 1'b1;
      chip_select_n  = ~on;
   endtask : read
endmodule : sacr_host
`default_nettype wire

/* sim/sacr_ctrl_tb.sv */
// Testbench for the conversion read control
`timescale 1ns/1ps
`default_nettype none
`include "sacr_cfg.svh"
module sacr_ctrl_tb;
   logic                    clk;
   logic                    rst_n;
   logic                    swap;
   logic [`SACR_DATA_W-1:0] core;
   wire                     rc_n;
   wire                     cs_n;
   wire                     busy_n;
   wire                     first;
   wire                     hold;
   wire  [`SACR_DATA_W-1:0] bits;
   wire  [`SACR_DATA_W-1:0] oe;
   int                      err_total;
   int                      total_checks;
   sacr_host host (.clk(clk), .read_convert_n(rc_n), .chip_select_n(cs_n));
   sacr_ctrl dut (.clk(clk), .rst_n(rst_n), .read_convert_n(rc_n),
      .chip_select_n(cs_n), .byte_lane_swap(swap), .conv_result(core),
      .busy_n(busy_n), .sample_hold(hold), .first_result(first),
      .result_bits_out(bits), .result_bits_oe(oe));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_sim
   // Old word checked mid-busy, then a stray command that must be ignored
   task automatic run_conv(input logic csm, input logic [15:0] val,
                           input logic fst, input logic [15:0] old);
      int          n;
      time         t0;
      logic [15:0] prev;
      n = 3;
      prev = 16'h0000;
      core = val;
      host.convert(csm);
      while (busy_n === 1'b1 && n < 8) begin
         @(negedge clk);
         n++;
      end
      check(16'(n <= 6), 16'h0001);
      check(16'(hold), 16'h0001);
      t0 = $time;
      host.read(1'b1);
      repeat (6) @(negedge clk);
      check(oe, 16'hffff);
      if (!fst) check(bits, old);
      host.convert(csm);
      // A clock between the two tasks keeps each line to one change a step
      @(negedge clk);
      host.read(1'b1);
      while (busy_n !== 1'b1 && ($time - t0) < 5000) begin
         prev = bits;
         @(negedge clk);
      end
      check(prev, val);
      check(16'(($time - t0) / 50), 16'd80);
      check(16'(hold), 16'h0000);
      repeat (2) @(negedge clk);
      check(bits, val);
      check(oe, 16'hffff);
      check(16'(first), 16'(fst));
      swap = 1'b1;
      repeat (2) @(negedge clk);
      check(bits, {val[7:0], val[15:8]});
      swap = 1'b0;
      host.read(1'b0);
      repeat (6) @(negedge clk);
      check(oe, 16'h0000);
      $display("conversion %h done", val);
   endtask : run_conv
   // Commands every 5 us; each must end before the next one comes
   task automatic run_rate(input logic [15:0] val);
      repeat (2) begin
         core = val;
         host.convert(1'b0);
         repeat (7) @(negedge clk);
         check(16'(busy_n), 16'h0000);
         repeat (90) @(negedge clk);
         check(16'(busy_n), 16'h0001);
         check(bits, val);
         val = ~val;
      end
      $display("rate test done");
   endtask : run_rate
   initial begin
      rst_n = 1'b0;
      swap = 1'b0;
      core = 16'h0000;
      err_total = 0;
      total_checks = 0;
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      check(16'(busy_n), 16'h0001);
      check(oe, 16'h0000);
      run_conv(1'b0, 16'h8001, 1'b1, 16'h0000);
      run_conv(1'b1, 16'h7ffe, 1'b0, 16'h8001);
      run_conv(1'b0, 16'h1234, 1'b0, 16'h7ffe);
      run_rate(16'h4321);
      end_sim();
   end
   // Five conversions take well under a thousand cycles
   initial begin
      repeat (3000) @(posedge clk);
      err_total++;
      end_sim();
   end
endmodule : sacr_ctrl_tb
`default_nettype wire
